// ---- verification/acss_host_model.sv ----
`timescale 1ns/1ps
// Host bus master: one bus cycle per call
module acss_host_model (
  // Clock
  input  wire logic       clk,
  // Host bus
  output logic      [3:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata
);
  // Idle bus at time zero
  initial begin
    {io_addr, io_wr, io_rd, io_wdata} = '0;
  end
  // Strobes held over one edge; next call replaces them
  task automatic cycle(input logic w, input logic r,
                       input logic [3:0] a, input logic [7:0] d);
    {io_addr, io_wr, io_rd, io_wdata} = {a, w, r, d};
    @(posedge clk);
    #1;
  endtask : cycle
endmodule : acss_host_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import acss_pkg::*;
  // ---------------------------------------------
  // Signals and expected state
  // ---------------------------------------------
  logic clk = 0, arst_n = 0, trig = 0;
  logic leg = 0, ff = 0, avg = 0, diff = 0;
  logic [3:0] io_addr, act, e_ch, m;
  logic [7:0] io_wdata, rdata, e_reg, e_rd;
  logic io_wr, io_rd, hold, flag, f_rst, a_rst, v_rst, e_hold;
  logic [15:0] r = 16'h4fd8;
  logic [7:0] tbl [4] = '{8'hd3, 8'h19, 8'h56, 8'h65};
  int fails = 0, checked = 0, cnt = 0;
  always #5 clk = ~clk;
  acss_host_model u_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  acss_scan_sequencer DUT (.clk(clk), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(rdata), .legacy_mode_strap(leg),
    .fifo_superset_strap(ff), .averager_strap(avg), .diff_mode(diff),
    .conv_trigger(trig), .active_channel(act), .hold_strobe_out(hold),
    .conversion_active_flag(flag), .fifo_reset(f_rst),
    .acq_reset(a_rst), .avg_reset(v_rst));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // One clock: drive, then update the model and compare
  task automatic step(input logic w, input logic rd, input logic [3:0] a,
                      input logic [7:0] d, input logic t);
    logic ws;
    ws = w && a == SCAN_RANGE_OFFSET;
    trig = t;
    u_host.cycle(w, rd, a, d);
    m = diff ? DIFF_MASK : SE_MASK;
    if (ws) begin
      e_reg = d;
      e_ch = d[3:0] & m;
      e_hold = 1'b1;
      if (avg) cnt = AVG_RESET_CYC;
    end else begin
      cnt = (cnt > 0) ? cnt - 1 : 0;
      if (t && e_ch == (e_reg[7:4] & m)) begin
        e_ch = e_reg[3:0] & m;
        e_hold = 1'b1;
      end else if (t) begin
        if (e_ch == (e_reg[3:0] & m)) e_hold = 1'b0;
        e_ch = (e_ch + 4'h1) & m;
      end
    end
    if (rd) e_rd = (a == SCAN_RANGE_OFFSET) ? e_reg : UNMAPPED_READ;
    chk(8'(act), 8'(e_ch));
    chk(8'(hold), 8'(e_hold));
    chk(8'(flag), 8'(cnt > 0));
    chk(8'(f_rst), 8'(ws & (ff | leg)));
    chk(8'(a_rst), 8'(ws));
    chk(8'(v_rst), 8'(ws & avg));
    chk(rdata, e_rd);
  endtask : step
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    e_reg = SCAN_RANGE_RESET;
    e_ch = CHAN_RESET;
    e_hold = 1'b1;
    e_rd = 8'h00;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    step(1'b0, 1'b1, 4'h2, 8'h00, 1'b0);
    // Every strap combination, mapped and unmapped reads
    for (int i = 0; i < 8; i++) begin
      {avg, ff, leg} = 3'(i);
      step(1'b1, 1'b0, 4'h2, 8'hd3, 1'b0);
      step(1'b0, 1'b1, i[0] ? 4'h2 : 4'h5, 8'h00, 1'b1);
    end
    // Ranges in both modes; ascending, then two wrapping ones (0x19 is one channel in diff mode), then ascending
    foreach (tbl[k]) for (int dm = 0; dm < 2; dm++) begin
      diff = dm[0];
      step(1'b1, 1'b0, 4'h2, tbl[k], 1'b0);
      repeat (18) step(1'b0, 1'b0, 4'h2, 8'h00, 1'b1);
    end
    // Random traffic; bench tracks channel order itself
    repeat (3000) begin
      r = nx(r);
      {ff, leg} = r[15:14];
      if (r[2:0] == 3'h0 && r[3]) diff = r[8];
      step(r[2:0] == 3'h0, r[2:0] != 3'h0 && r[11:10] == 2'h0,
           r[3] ? 4'h2 : r[7:4], r[15:8], r[12]);
    end
    repeat (605) step(1'b0, 1'b0, 4'h2, 8'h00, 1'b0);
    // Reset in mid-run while busy, then idle values again
    step(1'b1, 1'b0, 4'h2, 8'h56, 1'b0);
    arst_n = 1'b0;
    @(posedge clk);
    #1 arst_n = 1'b1;
    e_reg = SCAN_RANGE_RESET;
    e_ch = CHAN_RESET;
    e_hold = 1'b1;
    e_rd = 8'h00;
    cnt = 0;
    step(1'b0, 1'b1, 4'h2, 8'h00, 1'b0);
    stop_test();
  end
  // Watchdog well beyond the planned run
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : tb

// ---- verilog/acss_pkg.sv ----
package acss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SCAN_RANGE_OFFSET = 4'h2;
  localparam logic [7:0] SCAN_RANGE_RESET  = 8'h00;
  localparam int         FIRST_LSB         = 0;
  localparam int         LAST_LSB          = 4;
  localparam int         CHAN_W            = 4;
  localparam logic [3:0] CHAN_RESET        = 4'h0;
  localparam logic [3:0] SE_MASK           = 4'hf;
  localparam logic [3:0] DIFF_MASK         = 4'h7;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int AVG_RESET_NS   = 6000;
  localparam int AVG_RESET_CYC  = AVG_RESET_NS / CLK_PERIOD_NS;
  localparam int AVG_CNT_W      = 10;

endpackage : acss_pkg

// ---- verilog/acss_scan_sequencer.sv ----
`timescale 1ns/1ps
module acss_scan_sequencer
  import acss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Host I/O bus
  input  wire logic [3:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Straps and mode
  input  wire logic        legacy_mode_strap,
  input  wire logic        fifo_superset_strap,
  input  wire logic        averager_strap,
  input  wire logic        diff_mode,
  // Conversion trigger
  input  wire logic        conv_trigger,
  // Analog side and status
  output logic [3:0]       active_channel,
  output logic             hold_strobe_out,
  output logic             conversion_active_flag,
  // Reset pulses to neighbours
  output logic             fifo_reset,
  output logic             acq_reset,
  output logic             avg_reset
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] chan_mask(input logic [3:0] c,
                                           input logic       diff);
    chan_mask = diff ? (c & DIFF_MASK) : (c & SE_MASK);
  endfunction : chan_mask

  logic [7:0]           scan_q, scan_d;
  logic [3:0]           chan_q, chan_d;
  logic                 hold_q, hold_d;
  logic [7:0]           rdata_q, rdata_d;
  logic                 fifo_rst_q, fifo_rst_d;
  logic                 acq_rst_q, acq_rst_d;
  logic                 avg_rst_q, avg_rst_d;
  logic [AVG_CNT_W-1:0] avg_cnt_q, avg_cnt_d;
  logic                 busy_q, busy_d;
  logic                 scan_wr;
  logic [3:0]           first_m, last_m, chan_m;

  // Bus decode and masked views
  assign scan_wr = io_wr && (io_addr == SCAN_RANGE_OFFSET);
  assign first_m = chan_mask(scan_q[FIRST_LSB +: CHAN_W], diff_mode);
  assign last_m  = chan_mask(scan_q[LAST_LSB +: CHAN_W], diff_mode);
  assign chan_m  = chan_mask(chan_q, diff_mode);

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    scan_d = scan_q;
    chan_d = chan_q;
    hold_d = hold_q;
    if (scan_wr) begin
      scan_d = io_wdata;
      chan_d = chan_mask(io_wdata[FIRST_LSB +: CHAN_W], diff_mode);
      hold_d = 1'b1;
    end else if (conv_trigger) begin
      if (chan_m == last_m) begin
        chan_d = first_m;
        hold_d = 1'b1;
      end else begin
        chan_d = chan_mask(chan_m + 4'h1, diff_mode);
        if (chan_m == first_m) begin
          hold_d = 1'b0;
        end
      end
    end
  end

  // Read data, unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    if (io_rd) begin
      rdata_d = (io_addr == SCAN_RANGE_OFFSET) ? scan_q : UNMAPPED_READ;
    end
  end

  // Reset pulses and averager busy window
  always_comb begin
    fifo_rst_d = scan_wr && (fifo_superset_strap || legacy_mode_strap);
    acq_rst_d  = scan_wr;
    avg_rst_d  = scan_wr && averager_strap;
    avg_cnt_d  = avg_cnt_q;
    if (scan_wr && averager_strap) begin
      avg_cnt_d = AVG_CNT_W'(AVG_RESET_CYC);
    end else if (avg_cnt_q != '0) begin
      avg_cnt_d = avg_cnt_q - AVG_CNT_W'(1);
    end
    busy_d     = (avg_cnt_d != '0);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_q     <= SCAN_RANGE_RESET;
      chan_q     <= CHAN_RESET;
      hold_q     <= 1'b1;
      rdata_q    <= UNMAPPED_READ;
      fifo_rst_q <= 1'b0;
      acq_rst_q  <= 1'b0;
      avg_rst_q  <= 1'b0;
      avg_cnt_q  <= '0;
      busy_q     <= 1'b0;
    end else begin
      scan_q     <= scan_d;
      chan_q     <= chan_d;
      hold_q     <= hold_d;
      rdata_q    <= rdata_d;
      fifo_rst_q <= fifo_rst_d;
      acq_rst_q  <= acq_rst_d;
      avg_rst_q  <= avg_rst_d;
      avg_cnt_q  <= avg_cnt_d;
      busy_q     <= busy_d;
    end
  end

  // Outputs straight from flops
  assign io_rdata               = rdata_q;
  assign active_channel         = chan_q;
  assign hold_strobe_out        = hold_q;
  assign fifo_reset             = fifo_rst_q;
  assign acq_reset              = acq_rst_q;
  assign avg_reset              = avg_rst_q;
  assign conversion_active_flag = busy_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_write;
    scan_wr;
  endsequence

  sequence s_trig_only;
    conv_trigger && !scan_wr;
  endsequence

  property p_write_loads;
    s_write |=> scan_q == $past(io_wdata)
      && chan_q == chan_mask($past(io_wdata[3:0]), $past(diff_mode));
  endproperty
  a_write_loads: assert property (p_write_loads)
    else $error("scan write did not load channel");

  property p_quiet;
    !conv_trigger && !scan_wr |=> $stable(chan_q);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("channel changed without cause");

  property p_wrap;
    s_trig_only ##0 (chan_m == last_m) |=> chan_q == $past(first_m);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no reload at last channel");

  property p_step;
    s_trig_only ##0 (chan_m != last_m) |=>
      chan_q == chan_mask($past(chan_m) + 4'h1, $past(diff_mode));
  endproperty
  a_step: assert property (p_step)
    else $error("channel did not advance by one");

  property p_hold_high;
    s_write |=> hold_strobe_out;
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("hold strobe not high after write");

  property p_hold_low;
    s_trig_only ##0 (chan_m == first_m && chan_m != last_m)
      |=> !hold_strobe_out;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("hold strobe not low after first");

  property p_fifo;
    s_write |=> fifo_reset == $past(fifo_superset_strap || legacy_mode_strap);
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("fifo reset wrong");

  property p_acq;
    s_write |=> acq_reset;
  endproperty
  a_acq: assert property (p_acq)
    else $error("acquisition reset missing");

  property p_busy;
    s_write ##0 averager_strap |=> conversion_active_flag [*8];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag not held");

  // Cycles since the last averager reset, saturating past the window
  logic [AVG_CNT_W-1:0] busy_age_q, busy_age_d;

  always_comb begin
    busy_age_d = busy_age_q;
    if (scan_wr && averager_strap) begin
      busy_age_d = AVG_CNT_W'(1);
    end else if (busy_age_q != '0
                 && busy_age_q <= AVG_CNT_W'(AVG_RESET_CYC)) begin
      busy_age_d = busy_age_q + AVG_CNT_W'(1);
    end
  end

  // Age counter register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_age_q <= '0;
    end else begin
      busy_age_q <= busy_age_d;
    end
  end

  property p_busy_ends;
    (busy_age_q == '0 || busy_age_q > AVG_CNT_W'(AVG_RESET_CYC))
      |-> !conversion_active_flag;
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy flag too long");

  property p_busy_window;
    (busy_age_q != '0 && busy_age_q <= AVG_CNT_W'(AVG_RESET_CYC))
      |-> conversion_active_flag;
  endproperty
  a_busy_window: assert property (p_busy_window)
    else $error("busy flag dropped inside window");

  property p_hold_wrap;
    s_trig_only ##0 (chan_m == last_m) |=> hold_strobe_out;
  endproperty
  a_hold_wrap: assert property (p_hold_wrap)
    else $error("hold strobe not high after wrap");

endmodule : acss_scan_sequencer
